// [hdl/three_wire_serial_shifter.sv]
`timescale 1ns/1ps

// How it works
// - shift register directly read/written, unbuffered
// - msb routed to pin chosen by wire mode
// - output latch updates on opposite edge of external clock
// - serial input always from data-in pin
// - 4-bit counter, writable, overflow flag
// - shifter and counter share one clock source
// - external clock counts both edges
// - clock from pin, timer match, or strobe
// - two-wire start flag and clock hold
// - three-wire SPI mode 0/1, no select
// - eight clocks exchange master/slave bytes
// - toggle strobe flips serial clock pin
// - edge select picks sample/shift edges
// - sixteen edges overflow and set flag
// - overflow interrupt wakes idle processor
// - writing flag one clears it, loads counter
// - clock strobe also counts in rising external mode
// - software clocking up to fck/4
// - write wins over same-cycle shift
module three_wire_serial_shifter (
  input wire logic i_clock, // system clock, 20 MHz
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_enable, // clock enable, freezes state
  // shift_data_reg access
  input wire logic i_data_we, // write pulse
  input wire logic [7:0] i_data_wdata, // write value
  output logic [7:0] o_data, // shift register contents
  output logic [7:0] o_data_latched, // latched output byte
  // shifter_control_reg fields
  input wire logic i_ctrl_we, // control write pulse
  input wire logic i_start_int_en, // start interrupt enable
  input wire logic i_ovf_int_en, // overflow interrupt enable
  input wire logic [1:0] i_wire_mode, // wire mode field
  input wire logic i_clock_source_select, // external/timer source
  input wire logic i_clock_edge_select, // edge select
  input wire logic i_clock_strobe_bit, // software shift strobe
  input wire logic i_toggle_clock_strobe, // toggle clock pin
  // shifter_status_reg access
  input wire logic i_stat_we, // status write pulse
  input wire logic i_stat_ovf_clr, // one clears overflow flag
  input wire logic i_stat_start_clr, // one clears start flag
  input wire logic [3:0] i_stat_cnt, // counter load value
  output logic [3:0] o_count, // counter value
  output logic o_counter_overflow_flag, // overflow flag
  output logic o_start_flag, // start condition flag
  output logic o_irq_ovf, // overflow interrupt / wake
  output logic o_irq_start, // start interrupt
  // timer and pins
  input wire logic i_timer_match, // timer-zero compare pulse
  input wire logic i_serial_data_in, // data-in / sda pin
  input wire logic i_serial_clock_pin, // serial clock pin level
  output logic o_data_out, // three-wire data out pin
  output logic o_data_out_oe, // data out driven
  output logic o_sda_low, // two-wire data pulled low
  output logic o_sda_oe, // sda driven (open drain)
  output logic o_clock_pin_out, // serial clock port latch
  output logic o_clock_hold_oe // clock line held low
);

  typedef struct packed {
    logic [7:0] data;
    logic [3:0] cnt;
    logic ovf;
    logic start;
    logic out_latch;
    logic [7:0] data_latched;
    logic [1:0] wm;
    logic [1:0] cs;
    logic ovf_ie;
    logic start_ie;
    logic clk_port;
    logic clk_prev;
    logic sda_prev;
    logic hold;
    logic irq_ovf;
    logic irq_start;
    logic dout;
    logic dout_oe;
    logic sda_low;
    logic sda_oe;
    logic clk_out;
    logic hold_oe;
  } shifter_state_t;

  shifter_state_t state_r;
  shifter_state_t state_nxt;
  logic [1:0] pins_sync;
  logic clk_s;
  logic din_s;

  // local aliases of package encodings
  localparam logic [1:0] CS_SOFT_C = serial_shifter_pkg::CS_SOFT;
  localparam logic [1:0] CS_TIMER_C = serial_shifter_pkg::CS_TIMER;
  localparam logic [1:0] CS_RISE_C = serial_shifter_pkg::CS_EXT_RISE;
  localparam logic [1:0] CS_FALL_C = serial_shifter_pkg::CS_EXT_FALL;
  localparam logic [1:0] WM_THREE_C = serial_shifter_pkg::WM_THREE;
  localparam logic [1:0] WM_TWO_HOLD_C = serial_shifter_pkg::WM_TWO_HOLD;
  localparam logic [3:0] CNT_MAX_C = serial_shifter_pkg::CNT_MAX;

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_enable(i_enable),
    .i_async({i_serial_clock_pin, i_serial_data_in}),
    .o_sync(pins_sync)
  );

  assign clk_s = pins_sync[1];
  assign din_s = pins_sync[0];

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic [1:0] cs_now;
    logic rise;
    logic fall;
    logic shift_ev;
    logic count_ev;
    logic latch_ev;
    logic latch_open;
    logic clk_now;
    logic [1:0] wm_now;
    cs_now = state_r.cs;
    wm_now = state_r.wm;
    rise = 1'b0;
    fall = 1'b0;
    shift_ev = 1'b0;
    count_ev = 1'b0;
    latch_ev = 1'b0;
    latch_open = 1'b1;
    clk_now = 1'b0;
    state_nxt = state_r;
    if (i_enable) begin
      // control write: fields take effect from the next cycle
      if (i_ctrl_we) begin
        state_nxt.wm = i_wire_mode;
        state_nxt.cs = {i_clock_source_select, i_clock_edge_select};
        state_nxt.ovf_ie = i_ovf_int_en;
        state_nxt.start_ie = i_start_int_en;
        if (i_toggle_clock_strobe) begin
          state_nxt.clk_port = ~state_r.clk_port;
        end
      end
      // pin clock is always the synchronised pin, never the port latch
      clk_now = clk_s;
      rise = clk_now & ~state_r.clk_prev;
      fall = ~clk_now & state_r.clk_prev;
      state_nxt.clk_prev = clk_now;
      state_nxt.sda_prev = din_s;
      // clock source selection, both events from one source except strobe counts in rising external mode
      unique case (cs_now)
        CS_SOFT_C: begin
          shift_ev = i_ctrl_we & i_clock_strobe_bit;
          count_ev = shift_ev;
          latch_ev = shift_ev;
        end
        CS_TIMER_C: begin
          shift_ev = i_timer_match;
          count_ev = i_timer_match;
          latch_ev = i_timer_match;
        end
        CS_RISE_C: begin
          shift_ev = rise; // sample on rising
          latch_ev = fall; // data out moves on falling
          latch_open = ~clk_now; // shut while the clock is high
          // strobe counting with soft toggling
          count_ev = rise | fall
            | (i_ctrl_we & i_clock_strobe_bit);
        end
        CS_FALL_C: begin
          shift_ev = fall;
          latch_ev = rise;
          latch_open = clk_now; // shut while the clock is low
          count_ev = rise | fall;
        end
      endcase
      // shift; a same-cycle write wins
      if (i_data_we) begin
        state_nxt.data = i_data_wdata;
      end else if (shift_ev) begin
        state_nxt.data = {state_r.data[6:0], din_s};
      end
      // transparent output latch: open after the output-change edge, shut
      // from the sampling edge on, so outside falling mode with the clock idle low a fresh write shows on the pin before
      // the first edge and data out only moves on the opposite edge
      if (latch_open) begin
        state_nxt.out_latch = state_nxt.data[7];
      end
      if (latch_ev) begin
        state_nxt.data_latched = state_nxt.data;
      end
      // counter and overflow; a status write wins over a same-cycle set
      if (i_stat_we) begin
        state_nxt.cnt = i_stat_cnt;
        if (i_stat_ovf_clr) begin
          state_nxt.ovf = 1'b0;
          state_nxt.hold = 1'b0;
        end
        if (i_stat_start_clr) begin
          state_nxt.start = 1'b0;
        end
      end else if (count_ev) begin
        state_nxt.cnt = state_r.cnt + 4'h1;
      end
      if (count_ev && !i_stat_we && state_r.cnt == CNT_MAX_C) begin
        state_nxt.ovf = 1'b1;
        if (wm_now == WM_TWO_HOLD_C) begin
          state_nxt.hold = 1'b1;
        end
      end
      // two-wire start: sda falls while clock high
      if (wm_now[1] && clk_now && state_r.sda_prev && !din_s) begin
        state_nxt.start = 1'b1;
        state_nxt.hold = 1'b1;
      end
      // pin drive by wire mode
      state_nxt.dout = (wm_now == WM_THREE_C) & state_nxt.out_latch;
      state_nxt.dout_oe = (wm_now == WM_THREE_C);
      state_nxt.sda_low = 1'b0;
      state_nxt.sda_oe = wm_now[1] & ~state_nxt.out_latch;
      // hold only drives the line while the clock from the master is low
      state_nxt.hold_oe = wm_now[1] & state_nxt.hold & ~clk_now;
      state_nxt.clk_out = state_nxt.clk_port;
      // overflow interrupt also serves as idle wakeup
      state_nxt.irq_ovf = state_nxt.ovf & state_nxt.ovf_ie;
      state_nxt.irq_start = state_nxt.start & state_nxt.start_ie;
    end
  end

  // state register; reset clears data, counter, flag, mode
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // outputs, all from flip-flops
  // ==========================================================================
  assign o_data = state_r.data;
  assign o_data_latched = state_r.data_latched;
  assign o_count = state_r.cnt;
  assign o_counter_overflow_flag = state_r.ovf;
  assign o_start_flag = state_r.start;
  assign o_irq_ovf = state_r.irq_ovf;
  assign o_irq_start = state_r.irq_start;
  assign o_data_out = state_r.dout;
  assign o_data_out_oe = state_r.dout_oe;
  assign o_sda_low = state_r.sda_low;
  assign o_sda_oe = state_r.sda_oe;
  assign o_clock_pin_out = state_r.clk_out;
  assign o_clock_hold_oe = state_r.hold_oe;

  // ==========================================================================
  // checks
  // ==========================================================================
  chk_write_beats_shift: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && i_data_we |=> state_r.data == $past(i_data_wdata))
    else $error("written data not kept");

  chk_ovf_on_wrap: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && !i_stat_we && state_r.cnt == CNT_MAX_C
    && state_nxt.cnt == 4'h0
    |=> state_r.ovf && state_r.cnt == 4'h0)
    else $error("counter wrap without flag");

  chk_status_load: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && i_stat_we |=> state_r.cnt == $past(i_stat_cnt))
    else $error("counter not loaded");

  chk_toggle_pin: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && i_ctrl_we && i_toggle_clock_strobe
    |=> o_clock_pin_out != $past(o_clock_pin_out))
    else $error("clock pin did not toggle");

  chk_soft_shift: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && state_r.cs == 2'h0 && i_ctrl_we && i_clock_strobe_bit
    && !i_data_we |=> state_r.data[7:1] == $past(state_r.data[6:0]))
    else $error("strobe shift wrong");

  chk_freeze: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_enable |=> $stable(state_r))
    else $error("state moved while disabled");

  chk_dout_mode: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && state_r.wm != 2'h1 |=> !o_data_out_oe)
    else $error("data out driven outside three-wire");

  chk_irq_gate: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_irq_ovf |-> o_counter_overflow_flag)
    else $error("irq without flag");

  chk_irq_start_gate: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_irq_start
    |-> o_start_flag)
    else $error("start irq without flag");

  chk_start_detect: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && state_r.wm[1] && clk_s && state_r.sda_prev && !din_s
    |=> state_r.start && state_r.hold)
    else $error("start condition missed");

  chk_latch_shut: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && state_r.cs[1] && (clk_s ^ state_r.cs[0])
    |=> $stable(state_r.out_latch))
    else $error("output latch moved on sampling phase");

  chk_din_source: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && state_r.cs == CS_SOFT_C && i_ctrl_we && i_clock_strobe_bit
    && !i_data_we |=> state_r.data[0] == $past(din_s))
    else $error("shift input not from data-in pin");

  chk_data_out_pin: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_enable && state_r.wm == WM_THREE_C
    |=> o_data_out == state_r.out_latch)
    else $error("data out pin not the latched msb");

endmodule : three_wire_serial_shifter

// [hdl/serial_shifter_pkg.sv]
package serial_shifter_pkg;

  // ==========================================================================
  // widths and reset values
  // ==========================================================================
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 4;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_MAX = 4'hf;

  // ==========================================================================
  // wire mode and clock source encodings
  // ==========================================================================
  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO = 2'h2;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;

  // clock_source_select, clock_edge_select as a 2-bit field
  localparam logic [1:0] CS_SOFT = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [1:0] CS_EXT_RISE = 2'h2;
  localparam logic [1:0] CS_EXT_FALL = 2'h3;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned SYNC_STAGES = 2;

endpackage : serial_shifter_pkg

// [hdl/pin_sync.sv]
`timescale 1ns/1ps

// two-flop synchroniser for a group of pins
module pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic i_clock, // system clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_enable, // clock enable
  input wire logic [WIDTH-1:0] i_async, // raw pin levels
  output logic [WIDTH-1:0] o_sync // synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  // ==========================================================================
  // first stage is read only by the second
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    if (i_enable) begin
      state_nxt.meta = i_async;
      state_nxt.sync = state_r.meta;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_sync = state_r.sync;

endmodule : pin_sync

// [verification/spi_master_model.sv]
`timescale 1ns/1ps

// far-side three-wire master; its clock stands low between frames
module spi_master_model (
  output logic o_sck, // serial clock to the block
  output logic o_mosi, // data into the block
  input wire logic i_miso // data out of the block
);
  // ==========================================================================
  // idle levels
  // ==========================================================================
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b1;
  end

  // ==========================================================================
  // byte exchange, msb first
  // ==========================================================================
  // miso is taken at the end of the high phase, well after the block's
  // synchronised output change, so a slow half period suits mode 1
  task automatic xfer(input logic mode, input int half,
                      input logic [7:0] tx, output logic [7:0] rx);
    #13; // step off the block's clock edges so the pins never race it
    for (int i = 7; i >= 0; i--) begin
      if (!mode) o_mosi = tx[i];
      #(half);
      o_sck = 1'b1;
      if (mode) o_mosi = tx[i];
      #(half);
      rx[i] = i_miso;
      o_sck = 1'b0;
    end
    #(half);
    o_mosi = ~o_mosi; // released line shows no stale bit
  endtask : xfer
endmodule : spi_master_model

// [verification/testbench.sv]
`timescale 1ns/1ps

module testbench;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic clk, rst_n, data_we, ctrl_we, stat_we, strobe, tog, src, edg, tmr, en;
  logic ovf, stf, irq, irq_st, dout, dout_oe, sda_low, sda_oe, pin, hold;
  logic sck, mosi;
  logic [1:0] wm;
  logic [3:0] cnt_w, cnt;
  logic [4:0] s;
  logic [7:0] wdata, data, lat, rx, e, dv, tv;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  typedef struct packed {
    logic tm;
    logic [7:0] d;
    logic [3:0] c0;
    logic [4:0] n;
    logic din;
  } row_t;
  row_t rows [5];

  three_wire_serial_shifter three_wire_serial_shifter_i (
    .i_clock(clk), .i_reset_n(rst_n), .i_enable(en),
    .i_data_we(data_we), .i_data_wdata(wdata), .o_data(data),
    .o_data_latched(lat), .i_ctrl_we(ctrl_we), .i_start_int_en(1'b1),
    .i_ovf_int_en(1'b1), .i_wire_mode(wm), .i_clock_source_select(src),
    .i_clock_edge_select(edg), .i_clock_strobe_bit(strobe),
    .i_toggle_clock_strobe(tog), .i_stat_we(stat_we),
    .i_stat_ovf_clr(1'b1), .i_stat_start_clr(1'b1), .i_stat_cnt(cnt_w),
    .o_count(cnt), .o_counter_overflow_flag(ovf), .o_start_flag(stf),
    .o_irq_ovf(irq), .o_irq_start(irq_st), .i_timer_match(tmr),
    .i_serial_data_in(mosi), .i_serial_clock_pin(sck), .o_data_out(dout),
    .o_data_out_oe(dout_oe), .o_sda_low(sda_low), .o_sda_oe(sda_oe),
    .o_clock_pin_out(pin), .o_clock_hold_oe(hold));

  spi_master_model spi_master_model_i (
    .o_sck(sck), .o_mosi(mosi), .i_miso(dout));

  // ==========================================================================
  // clock and hang guard
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // whole run is about 500 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one control write per two cycles, the fastest software pace
  task automatic ctrl(input logic [1:0] m, input logic [1:0] cs,
                      input logic st, input logic tg);
    @(posedge clk);
    ctrl_we <= 1'b1;
    wm <= m;
    {src, edg} <= cs;
    strobe <= st;
    tog <= tg;
    @(posedge clk);
    ctrl_we <= 1'b0;
    strobe <= 1'b0;
    tog <= 1'b0;
  endtask : ctrl

  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    data_we <= 1'b1;
    wdata <= d;
    @(posedge clk);
    data_we <= 1'b0;
  endtask : wr

  task automatic stat(input logic [3:0] c);
    @(posedge clk);
    stat_we <= 1'b1;
    cnt_w <= c;
    @(posedge clk);
    stat_we <= 1'b0;
  endtask : stat

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {rst_n, data_we, ctrl_we, stat_we, strobe, tog, src, edg, tmr} = '0;
    {wm, cnt_w, wdata} = '0;
    en = 1'b1;
    rows = '{'{1'b0, 8'ha5, 4'h0, 5'h01, 1'b0},
             '{1'b0, 8'h3c, 4'h0, 5'h05, 1'b1},
             '{1'b0, 8'h81, 4'h1, 5'h0f, 1'b0},
             '{1'b1, 8'hc3, 4'he, 5'h03, 1'b1},
             '{1'b1, 8'h5a, 4'h0, 5'h02, 1'b0}};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // soft strobe and timer rows: shift and count per clock event
    foreach (rows[i]) begin
      ctrl(serial_shifter_pkg::WM_THREE, rows[i].tm ?
           serial_shifter_pkg::CS_TIMER : serial_shifter_pkg::CS_SOFT, 0, 0);
      spi_master_model_i.o_mosi <= rows[i].din;
      wr(rows[i].d);
      stat(rows[i].c0);
      repeat (3) @(posedge clk);
      e = rows[i].d;
      s = {1'b0, rows[i].c0} + rows[i].n;
      for (int k = 0; k < rows[i].n; k++) begin
        e = {e[6:0], rows[i].din};
        if (rows[i].tm) begin
          @(posedge clk);
          tmr <= 1'b1;
          @(posedge clk);
          tmr <= 1'b0;
        end else begin
          ctrl(serial_shifter_pkg::WM_THREE, serial_shifter_pkg::CS_SOFT,
               1'b1, 1'b0);
        end
      end
      repeat (2) @(posedge clk);
      check("row data", e, data);
      check("row count", {4'h0, s[3:0]}, {4'h0, cnt});
      check("row flags", {6'h0, s[4], s[4]}, {6'h0, ovf, irq});
    end
    // ring exchange with the far master in both external clock modes
    for (int m = 0; m < 2; m++) begin
      dv = m ? 8'h69 : 8'h96;
      tv = m ? 8'ha4 : 8'h5b;
      ctrl(serial_shifter_pkg::WM_THREE, m ? serial_shifter_pkg::CS_EXT_FALL
           : serial_shifter_pkg::CS_EXT_RISE, 1'b0, 1'b0);
      wr(dv);
      stat(4'h0);
      repeat (4) @(posedge clk);
      check("data out enable", 8'h01, {7'h0, dout_oe});
      spi_master_model_i.xfer(m[0], m ? 400 : 200, tv, rx);
      repeat (8) @(posedge clk);
      check("block received", tv, data);
      check("master received", dv, rx);
      check("latched copy", m ? 8'hd2 : 8'h5b, lat);
      check("edge count", 8'h01, {cnt, 3'h0, ovf});
    end
    // data write in the same cycle as a strobe keeps the written byte
    ctrl(serial_shifter_pkg::WM_THREE, serial_shifter_pkg::CS_SOFT, 0, 0);
    @(posedge clk);
    {data_we, ctrl_we, strobe} <= 3'h7;
    wdata <= 8'hc6;
    {src, edg} <= serial_shifter_pkg::CS_SOFT;
    @(posedge clk);
    {data_we, ctrl_we, strobe} <= 3'h0;
    repeat (2) @(posedge clk);
    check("write wins", 8'hc6, data);
    // toggle plus count strobe in rising external mode
    ctrl(serial_shifter_pkg::WM_THREE, serial_shifter_pkg::CS_EXT_RISE, 0, 0);
    stat(4'h0);
    for (int k = 0; k < 16; k++) begin
      ctrl(serial_shifter_pkg::WM_THREE, serial_shifter_pkg::CS_EXT_RISE, 1, 1);
      @(posedge clk);
      if (k == 0) check("first toggle", 8'h11, {cnt, 3'h0, pin});
    end
    check("sixteen toggles", 8'h01, {cnt, pin, 2'h0, ovf});
    // software clocking at the fastest pace, toggle alone then with strobe
    ctrl(serial_shifter_pkg::WM_THREE, serial_shifter_pkg::CS_SOFT, 0, 0);
    wr(8'hb7);
    stat(4'h0);
    spi_master_model_i.o_mosi <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      ctrl(serial_shifter_pkg::WM_THREE, serial_shifter_pkg::CS_SOFT, 0, 1);
      ctrl(serial_shifter_pkg::WM_THREE, serial_shifter_pkg::CS_SOFT, 1, 1);
    end
    repeat (2) @(posedge clk);
    check("fast data", 8'h7f, data);
    check("fast count", 8'h40, {cnt, pin, 3'h0});
    // clock enable low freezes everything, strobes included
    en <= 1'b0;
    ctrl(serial_shifter_pkg::WM_THREE, serial_shifter_pkg::CS_SOFT, 1, 1);
    en <= 1'b1;
    repeat (2) @(posedge clk);
    check("frozen data", 8'h7f, data);
    check("frozen count", 8'h40, {cnt, pin, 3'h0});
    // two-wire mode steers the msb to the open-drain data line
    ctrl(serial_shifter_pkg::WM_TWO, serial_shifter_pkg::CS_SOFT, 0, 0);
    for (int k = 0; k < 2; k++) begin
      wr(k ? 8'h80 : 8'h00);
      repeat (4) @(posedge clk);
      check("sda pull", {7'h0, !k}, {7'h0, sda_oe});
    end
    // start condition: data falls while the clock pin is high
    ctrl(serial_shifter_pkg::WM_TWO_HOLD, serial_shifter_pkg::CS_SOFT, 0, 0);
    spi_master_model_i.o_mosi <= 1'b1;
    spi_master_model_i.o_sck <= 1'b1;
    repeat (4) @(posedge clk);
    spi_master_model_i.o_mosi <= 1'b0;
    repeat (4) @(posedge clk);
    check("start seen", 8'h03, {6'h0, stf, irq_st});
    spi_master_model_i.o_sck <= 1'b0;
    repeat (4) @(posedge clk);
    check("clock held", 8'h01, {7'h0, hold});
    stat(4'h0);
    repeat (2) @(posedge clk);
    check("start cleared", 8'h00, {5'h0, stf, irq_st, hold});
    // second reset in mid-run returns everything to idle
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("reset data", 8'h00, data);
    check("reset state", 8'h00, {cnt, ovf, dout_oe, sda_oe, pin});
    check("reset start", 8'h00, {5'h0, stf, irq_st, hold});
    check("reset irq", 8'h00, {6'h0, irq, sda_low});
    check("reset copy", 8'h00, lat);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule : testbench
